// >>> core/fcm_defines.vh
// register map, field positions and constants of the fast counter block
// What this block does
// [R1] A software mode code picks the counter function; code 0 counts nothing.
// [R2] Mode 1: one up-counter on input 0, end value drives the output.
// [R3] Mode 2: up-count input 0 only while input 1 enables; output at end.
// [R4] Input-only variants: software copies the status end flag to another output.
// [R5] Modes 3 and 4: two up/down counters, no output; mode 4 inverts input 1.
// [R6] Without an output channel the end-value flag is read from the status byte.
// [R7] Mode 5: up/down counter loaded by a rising edge on the set input.
// [R8] Mode 6: up/down counter loaded by a falling edge on the set input.
// [R9] Mode 7: quadrature tracks A and B, single evaluation, direction counted.
// [R10] Quadrature modes ignore any index track; only A and B count.
// [R11] Mode 9: count both edges of track A, direction from track B.
// [R12] Mode 10: count both edges of both tracks, fourfold resolution.
// [R13] Mode 8 and codes above 10 are reserved and act like mode 0.
`ifndef FCM_DEFINES_VH
`define FCM_DEFINES_VH

`define FCM_CNT_W         16
`define FCM_ADDR_W        6

// byte offsets on the bus
`define FCM_OFF_CTRL      6'h00
`define FCM_OFF_END0      6'h04
`define FCM_OFF_END1      6'h08
`define FCM_OFF_PRESET    6'h0C
`define FCM_OFF_COUNT0    6'h10
`define FCM_OFF_COUNT1    6'h14
`define FCM_OFF_STATUS    6'h18
`define FCM_OFF_IRQ_STAT  6'h1C
`define FCM_OFF_IRQ_MASK  6'h20

// control register fields
`define FCM_CTRL_MODE_LSB 0
`define FCM_CTRL_MODE_MSB 3
`define FCM_CTRL_DIR0     4
`define FCM_CTRL_DIR1     5
`define FCM_CTRL_CLEAR    8

// status byte and interrupt bit positions
`define FCM_ST_END0       0
`define FCM_ST_END1       1
`define FCM_ST_MODE_LSB   4
`define FCM_IRQ_END0      0
`define FCM_IRQ_END1      1
`define FCM_IRQ_SET       2
`define FCM_IRQ_W         3

// mode codes
`define FCM_MODE_OFF      4'h0
`define FCM_MODE_UP_OUT   4'h1
`define FCM_MODE_UP_EN    4'h2
`define FCM_MODE_DUAL     4'h3
`define FCM_MODE_DUAL_INV 4'h4
`define FCM_MODE_SET_RISE 4'h5
`define FCM_MODE_SET_FALL 4'h6
`define FCM_MODE_QUAD_X1  4'h7
`define FCM_MODE_RSVD8    4'h8
`define FCM_MODE_QUAD_X2  4'h9
`define FCM_MODE_QUAD_X4  4'hA

// reset values
`define FCM_RST_CTRL      32'h0000_0000
`define FCM_RST_END       16'hFFFF
`define FCM_RST_PRESET    16'h0000

// input rate limits per mode group, kHz, against a 25000 kHz hclk
`define FCM_HCLK_KHZ      25000
`define FCM_RATE_STD_KHZ  50
`define FCM_RATE_X2_KHZ   30
`define FCM_RATE_X4_KHZ   15

`endif

// >>> core/fcm_insync.v
// two-flop input synchroniser with a previous-level stage for edge detection
`timescale 1ns/1ns
module fcm_insync (
   input  wire hclk,     // system clock
   input  wire hresetn,  // async reset, active low
   input  wire pin_a,    // raw input channel 0
   input  wire pin_b,    // raw input channel 1
   output reg  lvl_a,    // synchronised level a
   output reg  lvl_b,    // synchronised level b
   output reg  prv_a,    // level a one cycle earlier
   output reg  prv_b     // level b one cycle earlier
);
   reg meta_a_q;
   reg meta_b_q;

   // first stage is read by the second stage only
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_a_q <= 1'b0;
         meta_b_q <= 1'b0;
         lvl_a    <= 1'b0;
         lvl_b    <= 1'b0;
         prv_a    <= 1'b0;
         prv_b    <= 1'b0;
      end else begin
         meta_a_q <= pin_a;
         meta_b_q <= pin_b;
         lvl_a    <= meta_a_q;
         lvl_b    <= meta_b_q;
         prv_a    <= lvl_a;
         prv_b    <= lvl_b;
      end
   end
endmodule // fcm_insync

// >>> core/fcm_updown.v
// one up/down counter with clear and load
`timescale 1ns/1ns
`include "fcm_defines.vh"
module fcm_updown (
   input  wire                     hclk,     // system clock
   input  wire                     hresetn,  // async reset, active low
   input  wire                     clr,      // clear to zero
   input  wire                     load,     // load load_val
   input  wire [`FCM_CNT_W-1:0]    load_val, // value to load
   input  wire                     inc,      // count up one
   input  wire                     dec,      // count down one
   output reg  [`FCM_CNT_W-1:0]    cnt_q     // counter value
);
   reg [`FCM_CNT_W-1:0] cnt_d;

   // clear beats load beats counting; inc and dec together cancel
   always @* begin
      cnt_d = cnt_q;
      if (clr) begin
         cnt_d = {`FCM_CNT_W{1'b0}};
      end else if (load) begin
         cnt_d = load_val;
      end else if (inc && !dec) begin
         cnt_d = cnt_q + 1'b1;
      end else if (dec && !inc) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= {`FCM_CNT_W{1'b0}};
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule // fcm_updown

// >>> core/fcm_top.v
// fast counter block: mode decode, edge counting, end flags, AHB-Lite registers
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
`include "fcm_defines.vh"
module fcm_top (
   input  wire        hclk,                         // system clock, 25 MHz
   input  wire        hresetn,                      // async reset, active low
   input  wire        hsel,                         // slave select
   input  wire [31:0] haddr,                        // byte address
   input  wire [1:0]  htrans,                       // transfer type
   input  wire        hwrite,                       // write when high
   input  wire [2:0]  hsize,                        // transfer size
   input  wire [31:0] hwdata,                       // write data
   input  wire        hready,                       // bus ready
   output reg  [31:0] hrdata,                       // read data
   output reg         hreadyout,                    // slave ready
   output reg         hresp,                        // response, always OKAY
   input  wire        digital_input_channel0,       // count input / track A
   input  wire        digital_input_channel1,       // enable, set, count or track B
   output reg         configurable_io_channel_o,    // end-value output level
   output reg         configurable_io_channel_oe_n, // low while output driven
   output reg         irq                           // level interrupt
);

   // reserved codes fold onto the off mode
   function [3:0] eff_mode;
      input [3:0] m;
      begin
         if (m == `FCM_MODE_RSVD8 || m > `FCM_MODE_QUAD_X4) begin
            eff_mode = `FCM_MODE_OFF; // [R13]
         end else begin
            eff_mode = m; // [R1]
         end
      end
   endfunction

   // up-only modes flag from the end value on; up/down modes flag on equality
   function reached;
      input [`FCM_CNT_W-1:0] cnt;
      input [`FCM_CNT_W-1:0] endv;
      input                  up_only;
      begin
         if (up_only) begin
            reached = (cnt >= endv);
         end else begin
            reached = (cnt == endv);
         end
      end
   endfunction

   // ---------------- registers ----------------
   reg  [3:0]            mode_q;
   reg                   dir0_q;
   reg                   dir1_q;
   reg  [`FCM_CNT_W-1:0] end0_q;
   reg  [`FCM_CNT_W-1:0] end1_q;
   reg  [`FCM_CNT_W-1:0] preset_q;
   reg  [`FCM_IRQ_W-1:0] irq_stat_q;
   reg  [`FCM_IRQ_W-1:0] irq_mask_q;
   reg                   clear_q;
   reg                   end0_q_lvl;
   reg                   end1_q_lvl;
   reg                   end0_prev_q;
   reg                   end1_prev_q;
   reg  [3:0]            act_mode_q;

   // bus pipeline
   reg                   wr_pend_q;
   reg                   rd_pend_q;
   reg  [`FCM_ADDR_W-1:0] bus_addr_q;

   wire [`FCM_CNT_W-1:0] cnt0;
   wire [`FCM_CNT_W-1:0] cnt1;
   wire                  a_lvl;
   wire                  b_lvl;
   wire                  a_prv;
   wire                  b_prv;

   // ---------------- input synchroniser ----------------
   fcm_insync u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin_a   (digital_input_channel0),
      .pin_b   (digital_input_channel1),
      .lvl_a   (a_lvl),
      .lvl_b   (b_lvl),
      .prv_a   (a_prv),
      .prv_b   (b_prv)
   );

   wire rise_a = a_lvl & ~a_prv;
   wire fall_a = ~a_lvl & a_prv;
   wire rise_b = b_lvl & ~b_prv;
   wire fall_b = ~b_lvl & b_prv;

   wire [3:0] m = eff_mode(mode_q);

   // ---------------- count decode ----------------
   reg inc0;
   reg dec0;
   reg inc1;
   reg dec1;
   reg load0;
   reg up_only0;
   reg uses_ch1;

   always @* begin
      inc0     = 1'b0;
      dec0     = 1'b0;
      inc1     = 1'b0;
      dec1     = 1'b0;
      load0    = 1'b0;
      up_only0 = 1'b0;
      uses_ch1 = 1'b0;
      case (m)
         `FCM_MODE_OFF: begin
            inc0 = 1'b0; // [R1]
         end
         `FCM_MODE_UP_OUT: begin
            inc0     = rise_a; // [R2]
            up_only0 = 1'b1;
         end
         `FCM_MODE_UP_EN: begin
            inc0     = rise_a & b_lvl; // [R3]
            up_only0 = 1'b1;
         end
         `FCM_MODE_DUAL: begin
            inc0     = rise_a & ~dir0_q; // [R5]
            dec0     = rise_a & dir0_q;
            inc1     = rise_b & ~dir1_q;
            dec1     = rise_b & dir1_q;
            uses_ch1 = 1'b1;
         end
         `FCM_MODE_DUAL_INV: begin
            // input 1 inverted, so its active edge is the falling one
            inc0     = rise_a & ~dir0_q; // [R5]
            dec0     = rise_a & dir0_q;
            inc1     = fall_b & ~dir1_q; // [R5]
            dec1     = fall_b & dir1_q;
            uses_ch1 = 1'b1;
         end
         `FCM_MODE_SET_RISE: begin
            inc0  = rise_a & ~dir0_q;
            dec0  = rise_a & dir0_q;
            load0 = rise_b; // [R7]
         end
         `FCM_MODE_SET_FALL: begin
            inc0  = rise_a & ~dir0_q;
            dec0  = rise_a & dir0_q;
            load0 = fall_b; // [R8]
         end
         `FCM_MODE_QUAD_X1: begin
            // A rising while B low means A leads: count up
            inc0 = rise_a & ~b_lvl; // [R9]
            dec0 = rise_a & b_lvl; // [R9]
         end
         `FCM_MODE_QUAD_X2: begin
            inc0 = (rise_a & ~b_lvl) | (fall_a & b_lvl); // [R11]
            dec0 = (rise_a & b_lvl) | (fall_a & ~b_lvl); // [R11]
         end
         `FCM_MODE_QUAD_X4: begin
            // both tracks moving in one sample is a step lost, not counted
            if (!((rise_a | fall_a) && (rise_b | fall_b))) begin
               inc0 = (rise_a & ~b_lvl) | (fall_a & b_lvl)
                    | (rise_b & a_lvl) | (fall_b & ~a_lvl); // [R12]
               dec0 = (rise_a & b_lvl) | (fall_a & ~b_lvl)
                    | (rise_b & ~a_lvl) | (fall_b & a_lvl); // [R12]
            end
         end
         default: begin
            inc0 = 1'b0; // [R13]
         end
      endcase
   end
   // no index track enters the decode at all: only A and B count  [R10]

   // counters restart whenever the active mode changes
   wire mode_chg = (m != act_mode_q);

   fcm_updown u_cnt0 (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .clr      (clear_q | mode_chg),
      .load     (load0),
      .load_val (preset_q),
      .inc      (inc0),
      .dec      (dec0),
      .cnt_q    (cnt0)
   );

   fcm_updown u_cnt1 (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .clr      (clear_q | mode_chg),
      .load     (1'b0),
      .load_val (preset_q),
      .inc      (inc1),
      .dec      (dec1),
      .cnt_q    (cnt1)
   );

   // ---------------- end flags and output pin ----------------
   wire drives_out = (m == `FCM_MODE_UP_OUT) || (m == `FCM_MODE_UP_EN);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         end0_q_lvl                   <= 1'b0;
         end1_q_lvl                   <= 1'b0;
         end0_prev_q                  <= 1'b0;
         end1_prev_q                  <= 1'b0;
         act_mode_q                   <= `FCM_MODE_OFF;
         configurable_io_channel_o    <= 1'b0;
         configurable_io_channel_oe_n <= 1'b1;
      end else begin
         act_mode_q  <= m;
         end0_q_lvl  <= (m != `FCM_MODE_OFF) & reached(cnt0, end0_q, up_only0); // [R6]
         end1_q_lvl  <= uses_ch1 & reached(cnt1, end1_q, 1'b0); // [R6]
         end0_prev_q <= end0_q_lvl;
         end1_prev_q <= end1_q_lvl;
         // pin released in every mode without an output channel
         configurable_io_channel_o    <= drives_out & end0_q_lvl; // [R2] [R3]
         configurable_io_channel_oe_n <= ~drives_out; // [R5] [R1]
      end
   end

   wire [`FCM_IRQ_W-1:0] irq_ev;
   assign irq_ev[`FCM_IRQ_END0] = end0_q_lvl & ~end0_prev_q;
   assign irq_ev[`FCM_IRQ_END1] = end1_q_lvl & ~end1_prev_q;
   assign irq_ev[`FCM_IRQ_SET]  = load0;

   // ---------------- AHB-Lite slave ----------------
   wire take = hsel & htrans[1] & hready;
   wire wr_now = wr_pend_q;

   function sel;
      input [`FCM_ADDR_W-1:0] a;
      input [`FCM_ADDR_W-1:0] off;
      begin
         sel = (a == off);
      end
   endfunction

   // status byte mirrors the end flags; software may copy them to any output
   wire [7:0] status_byte = {m, 2'b00, end1_q_lvl, end0_q_lvl}; // [R6]

   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h0000_0000;
      case (bus_addr_q)
         `FCM_OFF_CTRL: begin
            rd_mux[`FCM_CTRL_MODE_MSB:`FCM_CTRL_MODE_LSB] = mode_q;
            rd_mux[`FCM_CTRL_DIR0] = dir0_q;
            rd_mux[`FCM_CTRL_DIR1] = dir1_q;
         end
         `FCM_OFF_END0: begin
            rd_mux[`FCM_CNT_W-1:0] = end0_q;
         end
         `FCM_OFF_END1: begin
            rd_mux[`FCM_CNT_W-1:0] = end1_q;
         end
         `FCM_OFF_PRESET: begin
            rd_mux[`FCM_CNT_W-1:0] = preset_q;
         end
         `FCM_OFF_COUNT0: begin
            rd_mux[`FCM_CNT_W-1:0] = cnt0;
         end
         `FCM_OFF_COUNT1: begin
            rd_mux[`FCM_CNT_W-1:0] = cnt1;
         end
         `FCM_OFF_STATUS: begin
            rd_mux[7:0] = status_byte;
         end
         `FCM_OFF_IRQ_STAT: begin
            rd_mux[`FCM_IRQ_W-1:0] = irq_stat_q;
         end
         `FCM_OFF_IRQ_MASK: begin
            rd_mux[`FCM_IRQ_W-1:0] = irq_mask_q;
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   // reads take one wait state so the data always reflect a write just before
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q  <= 1'b0;
         rd_pend_q  <= 1'b0;
         bus_addr_q <= {`FCM_ADDR_W{1'b0}};
         hrdata     <= 32'h0000_0000;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
      end else begin
         hresp <= 1'b0;
         if (rd_pend_q) begin
            hrdata    <= rd_mux;
            hreadyout <= 1'b1;
            rd_pend_q <= 1'b0;
         end else if (take) begin
            bus_addr_q <= haddr[`FCM_ADDR_W-1:0];
            wr_pend_q  <= hwrite;
            rd_pend_q  <= ~hwrite;
            hreadyout  <= hwrite;
         end else begin
            wr_pend_q <= 1'b0;
         end
         if (rd_pend_q || take) begin
            if (!take || rd_pend_q) begin
               wr_pend_q <= 1'b0;
            end
         end
      end
   end

   // ---------------- register writes ----------------
   wire [`FCM_IRQ_W-1:0] w1c = (wr_now && sel(bus_addr_q, `FCM_OFF_IRQ_STAT))
                               ? hwdata[`FCM_IRQ_W-1:0] : {`FCM_IRQ_W{1'b0}};

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q     <= `FCM_MODE_OFF;
         dir0_q     <= 1'b0;
         dir1_q     <= 1'b0;
         clear_q    <= 1'b0;
         end0_q     <= `FCM_RST_END;
         end1_q     <= `FCM_RST_END;
         preset_q   <= `FCM_RST_PRESET;
         irq_mask_q <= {`FCM_IRQ_W{1'b0}};
         irq_stat_q <= {`FCM_IRQ_W{1'b0}};
         irq        <= 1'b0;
      end else begin
         clear_q <= 1'b0;
         if (wr_now) begin
            if (sel(bus_addr_q, `FCM_OFF_CTRL)) begin
               mode_q  <= hwdata[`FCM_CTRL_MODE_MSB:`FCM_CTRL_MODE_LSB]; // [R1]
               dir0_q  <= hwdata[`FCM_CTRL_DIR0];
               dir1_q  <= hwdata[`FCM_CTRL_DIR1];
               clear_q <= hwdata[`FCM_CTRL_CLEAR];
            end
            if (sel(bus_addr_q, `FCM_OFF_END0)) begin
               end0_q <= hwdata[`FCM_CNT_W-1:0];
            end
            if (sel(bus_addr_q, `FCM_OFF_END1)) begin
               end1_q <= hwdata[`FCM_CNT_W-1:0];
            end
            if (sel(bus_addr_q, `FCM_OFF_PRESET)) begin
               preset_q <= hwdata[`FCM_CNT_W-1:0];
            end
            if (sel(bus_addr_q, `FCM_OFF_IRQ_MASK)) begin
               irq_mask_q <= hwdata[`FCM_IRQ_W-1:0];
            end
         end
         // a new event in the clearing cycle survives the clear
         irq_stat_q <= (irq_stat_q & ~w1c) | irq_ev;
         irq        <= |(irq_stat_q & irq_mask_q);
      end
   end

endmodule // fcm_top

// >>> test/fcm_checker.sv
// port-level assertions for the fast counter block, bound to its top module
`timescale 1ns/1ns
module fcm_checker (
   input logic        hclk,                         // system clock
   input logic        hresetn,                      // async reset, active low
   input logic        hsel,                         // slave select
   input logic [1:0]  htrans,                       // transfer type
   input logic        hwrite,                       // write when high
   input logic        hready,                       // bus ready
   input logic [31:0] hrdata,                       // read data
   input logic        hreadyout,                    // slave ready
   input logic        hresp,                        // response
   input logic        digital_input_channel0,       // input 0
   input logic        digital_input_channel1,       // input 1
   input logic        configurable_io_channel_o,    // end-value output
   input logic        configurable_io_channel_oe_n, // output enable, low drives
   input logic        irq                           // level interrupt
);
   logic       take;
   logic [3:0] quiet_q;
   logic [3:0] quiet_d;
   logic       a_q;
   logic       b_q;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   assign take = hsel && htrans[1] && hready;
   // outputs move only shortly after a pin edge or a register write
   always_comb begin
      if ((take && hwrite) || a_q != digital_input_channel0 || b_q != digital_input_channel1)
         quiet_d = 4'h0;
      else
         quiet_d = (quiet_q == 4'hF) ? 4'hF : quiet_q + 4'h1;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         quiet_q <= 4'h0;
         a_q     <= 1'b0;
         b_q     <= 1'b0;
      end else begin
         quiet_q <= quiet_d;
         a_q     <= digital_input_channel0;
         b_q     <= digital_input_channel1;
      end
   end

   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("hresp not okay");
   property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   property p_wr_nowait; take && hwrite |=> hreadyout; endproperty
   a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
   property p_one_wait; !hreadyout |=> hreadyout; endproperty
   a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");
   property p_rdata_hold; hreadyout && $past(hreadyout) |-> $stable(hrdata); endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_out_drv;
      configurable_io_channel_o |-> !configurable_io_channel_oe_n;
   endproperty
   a_out_drv: assert property (p_out_drv) else $error("output high but not driven");
   property p_quiet;
      quiet_q >= 4'h8 |-> $stable(irq) && $stable(configurable_io_channel_o)
         && $stable(configurable_io_channel_oe_n);
   endproperty
   a_quiet: assert property (p_quiet) else $error("output moved without cause");
   property p_rst;
      $rose(hresetn) |-> hreadyout && !irq && configurable_io_channel_oe_n
         && !configurable_io_channel_o;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs wrong after reset");
endmodule // fcm_checker

bind fcm_top fcm_checker i_fcm_checker (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .digital_input_channel0(digital_input_channel0),
   .digital_input_channel1(digital_input_channel1),
   .configurable_io_channel_o(configurable_io_channel_o),
   .configurable_io_channel_oe_n(configurable_io_channel_oe_n), .irq(irq));

// >>> test/fcm_field_model.sv
// pulse source and quadrature encoder driving the two input channels
`timescale 1ns/1ns
module fcm_field_model (
   input  logic hclk,  // system clock
   output logic trk_a, // channel 0 level
   output logic trk_b  // channel 1 level
);
   initial begin
      trk_a = 1'b0;
      trk_b = 1'b0;
   end
   task automatic hold(input logic slow);
      repeat (slow ? 12 : 3) @(posedge hclk);
   endtask
   task automatic idle();
      {trk_a, trk_b} <= 2'b00;
      hold(1'b1);
   endtask
   // kind 0 pulses on a, 1 pulses on a inside a b window, 2 pulses on both with
   // b left high, 3 encoder forward, 4 encoder backward
   task automatic run(input logic [2:0] kind, input logic [7:0] n, input logic slow);
      int i;
      if (kind == 3'd1) begin
         trk_b <= 1'b1;
         hold(slow);
      end
      for (i = 0; i < n; i++) begin
         if (kind >= 3'd3) begin
            // one track per step, tracks a quarter cycle apart
            {trk_a, trk_b} <= (kind == 3'd3) ? 2'b10 : 2'b01;
            hold(slow);
            {trk_a, trk_b} <= 2'b11;
            hold(slow);
            {trk_a, trk_b} <= (kind == 3'd3) ? 2'b01 : 2'b10;
            hold(slow);
            {trk_a, trk_b} <= 2'b00;
            hold(slow);
         end else begin
            trk_a <= 1'b1;
            if (kind == 3'd2) trk_b <= 1'b1;
            hold(slow);
            trk_a <= 1'b0;
            if (kind == 3'd2 && i < n - 1) trk_b <= 1'b0;
            hold(slow);
         end
      end
      if (kind == 3'd1) begin
         trk_b <= 1'b0;
         hold(slow);
      end
   endtask
endmodule // fcm_field_model

// >>> test/fcm_top_tb.sv
// self-checking bench for the fast counter block
`timescale 1ns/1ns
`include "fcm_defines.vh"
module fcm_top_tb;
   typedef struct packed {
      logic [3:0]  mode;
      logic [1:0]  dir;
      logic [2:0]  kind;
      logic [15:0] e0;
      logic [15:0] e1;
      logic [3:0]  emode;
      logic        eoe;
   } fcm_row_t;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        ch_a;
   logic        ch_b;
   logic        io_o;
   logic        io_oe_n;
   logic        irq;
   logic [31:0] d;
   int          errors;
   int          checks_done;
   int          r;
   fcm_row_t rows [0:14] = '{
      '{4'h0, 2'b00, 3'd0, 16'h0000, 16'h0000, 4'h0, 1'b1},
      '{4'h1, 2'b00, 3'd0, 16'h0003, 16'h0000, 4'h1, 1'b0},
      '{4'h2, 2'b00, 3'd0, 16'h0000, 16'h0000, 4'h2, 1'b0},
      '{4'h2, 2'b00, 3'd1, 16'h0003, 16'h0000, 4'h2, 1'b0},
      '{4'h3, 2'b00, 3'd2, 16'h0003, 16'h0003, 4'h3, 1'b1},
      '{4'h3, 2'b11, 3'd2, 16'hFFFD, 16'hFFFD, 4'h3, 1'b1},
      '{4'h4, 2'b00, 3'd2, 16'h0003, 16'h0002, 4'h4, 1'b1},
      '{4'h5, 2'b00, 3'd1, 16'h0103, 16'h0000, 4'h5, 1'b1},
      '{4'h6, 2'b00, 3'd1, 16'h0100, 16'h0000, 4'h6, 1'b1},
      '{4'h7, 2'b00, 3'd3, 16'h0003, 16'h0000, 4'h7, 1'b1},
      '{4'h7, 2'b00, 3'd4, 16'hFFFD, 16'h0000, 4'h7, 1'b1},
      '{4'h9, 2'b00, 3'd3, 16'h0006, 16'h0000, 4'h9, 1'b1},
      '{4'hA, 2'b00, 3'd4, 16'hFFF4, 16'h0000, 4'hA, 1'b1},
      '{4'h8, 2'b00, 3'd2, 16'h0000, 16'h0000, 4'h0, 1'b1},
      '{4'hF, 2'b00, 3'd3, 16'h0000, 16'h0000, 4'h0, 1'b1}};

   fcm_top i_fcm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .digital_input_channel0(ch_a),
      .digital_input_channel1(ch_b), .configurable_io_channel_o(io_o),
      .configurable_io_channel_oe_n(io_oe_n), .irq(irq));
   fcm_field_model i_fcm_field_model (.hclk(hclk), .trk_a(ch_a), .trk_b(ch_b));

   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (k >= 50) begin
         errors++;
         stop_test();
      end
   endtask
   // single word transfer; read data taken at the edge that ends the data phase
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {26'h0, a};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      d = hrdata;
   endtask

   initial begin
      {hresetn, hsel, haddr, htrans, hwrite, hwdata, errors, checks_done} = '0;
      hsize = 3'b010;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(0, `FCM_OFF_CTRL, 0);     check(d, `FCM_RST_CTRL);
      bus(0, `FCM_OFF_END0, 0);     check(d, {16'h0, `FCM_RST_END});
      bus(0, `FCM_OFF_END1, 0);     check(d, {16'h0, `FCM_RST_END});
      bus(0, `FCM_OFF_PRESET, 0);   check(d, {16'h0, `FCM_RST_PRESET});
      bus(0, `FCM_OFF_IRQ_MASK, 0); check(d, 32'h0);
      $display("reset values done");
      bus(1, `FCM_OFF_PRESET, 32'h0000_0100);
      for (r = 0; r < 15; r++) begin
         i_fcm_field_model.idle();
         bus(1, `FCM_OFF_CTRL, {23'h0, 1'b1, 2'h0, rows[r].dir, rows[r].mode});
         i_fcm_field_model.run(rows[r].kind, 8'd3, r[0]);
         repeat (10) @(posedge hclk);
         bus(0, `FCM_OFF_COUNT0, 0);
         check(d, {16'h0, rows[r].e0});
         bus(0, `FCM_OFF_COUNT1, 0); check(d, {16'h0, rows[r].e1});
         bus(0, `FCM_OFF_STATUS, 0); check({28'h0, d[7:4]}, {28'h0, rows[r].emode});
         check({31'h0, io_oe_n}, {31'h0, rows[r].eoe});
         $display("row %0d done", r);
      end
      // end value in mode 1: pin, status, masked then unmasked interrupt
      i_fcm_field_model.idle();
      bus(1, `FCM_OFF_IRQ_STAT, 32'h7);
      bus(1, `FCM_OFF_END0, 32'h3);
      bus(1, `FCM_OFF_CTRL, {28'h0, `FCM_MODE_UP_OUT});
      i_fcm_field_model.run(3'd0, 8'd3, 1'b0);
      repeat (10) @(posedge hclk);
      check({31'h0, io_o}, 32'h1);
      check({31'h0, irq}, 32'h0);
      bus(0, `FCM_OFF_STATUS, 0);   check(d, 32'h11);
      bus(0, `FCM_OFF_IRQ_STAT, 0); check(d, 32'h1);
      bus(1, `FCM_OFF_IRQ_MASK, 32'h1);
      repeat (4) @(posedge hclk);
      check({31'h0, irq}, 32'h1);
      bus(1, `FCM_OFF_IRQ_STAT, 32'h1);
      repeat (4) @(posedge hclk);
      check({31'h0, irq}, 32'h0);
      $display("end value test done");
      // reset in mid-run drops the driven output and the mode
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check({30'h0, io_oe_n, io_o}, 32'h2);
      bus(0, `FCM_OFF_CTRL, 0); check(d, 32'h0);
      $display("second reset done");
      // end value with no output channel shows in the status byte only
      bus(1, `FCM_OFF_END0, 32'h2);
      bus(1, `FCM_OFF_CTRL, {28'h0, `FCM_MODE_DUAL});
      i_fcm_field_model.run(3'd2, 8'd2, 1'b1);
      repeat (10) @(posedge hclk);
      bus(0, `FCM_OFF_STATUS, 0); check(d, 32'h31);
      check({30'h0, io_oe_n, io_o}, 32'h2);
      bus(0, 6'h24, 0); check(d, 32'h0);
      $display("status and unmapped test done");
      stop_test();
   end
endmodule // fcm_top_tb
